// ===== logic/scd_core.sv
// Stack sense short detection, module temperature spread and contactor wear diagnostics
`timescale 1ns/1ps

module scd_core import scd_pkg::*; #(
  parameter int N_MOD = 4,
  parameter int N_TH = 4,
  parameter int N_CONT = 2,
  parameter int LOG2_SAMPLE_US = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Avalon-MM register slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Measurements from the front end
  input wire logic sample_valid,
  input wire logic signed [31:0] stack_current_ma,
  input wire logic signed [31:0] stack_voltage_mv,
  input wire logic [N_MOD*N_TH*16-1:0] module_temps_c,
  // Contactor events
  input wire logic [N_CONT-1:0] contactor_open,
  input wire logic [N_CONT-1:0] contactor_open_lost,
  // Diagnostic flags
  output logic short_sense_trip,
  output logic module_temp_spread_trip,
  output logic wearout_warning_level,
  output logic wearout_trip_level,
  output logic [N_CONT-1:0] contactor_eol
);
  logic short_en_reg;
  logic [31:0] i_thr_reg, v_thr_reg, i_tc_reg, v_tc_reg, act_time_reg, ramp_time_reg, sample_cnt_reg;
  logic [7:0] short_pct_reg, warn_pct_reg, fault_pct_reg;
  logic [15:0] temp_limit_reg;
  logic [N_CONT-1:0] mon_en_reg, life_en_reg, soft_start_reg;
  logic [31:0] window_reg [N_CONT];
  logic [31:0] min_i_reg [N_CONT];
  logic [31:0] max_i_reg [N_CONT];
  logic [31:0] rated_i_reg [N_CONT];
  logic [31:0] max_life_reg [N_CONT];
  logic [N_CONT-1:0] cnt_load;
  logic ack_reg;
  logic [31:0] rdata_next;
  logic wr_fire, rd_fire, clear_req;

  // Bus slave: one wait cycle, then the access completes
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wr_fire = avs_write && ack_reg;
  assign rd_fire = avs_read && !ack_reg;
  assign clear_req = wr_fire && avs_address == OFS_CTRL && avs_writedata[CTRL_CLEAR];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  // Time constants in microseconds become filter shifts
  function automatic logic [4:0] tc_shift(input logic [31:0] tc_us);
    logic [5:0] msb;
    msb = 6'h0;
    for (int i = 0; i < 32; i++) begin
      if (tc_us[i]) begin
        msb = 6'(i);
      end
    end
    if (msb <= 6'(LOG2_SAMPLE_US)) begin
      return 5'h0;
    end else if (msb - 6'(LOG2_SAMPLE_US) > {1'b0, LPF_MAX_SHIFT}) begin
      return LPF_MAX_SHIFT;
    end
    return 5'(msb - 6'(LOG2_SAMPLE_US));
  endfunction

  // Global settings
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      short_en_reg <= RST_SHORT_EN;
      i_thr_reg <= RST_I_THR;
      v_thr_reg <= RST_V_THR;
      i_tc_reg <= RST_TC_US;
      v_tc_reg <= RST_TC_US;
      act_time_reg <= RST_ACT_US;
      ramp_time_reg <= RST_RAMP_US;
      sample_cnt_reg <= RST_SAMPLE_CNT;
      short_pct_reg <= RST_SHORT_PCT;
      temp_limit_reg <= RST_TEMP_LIMIT;
      warn_pct_reg <= RST_WARN_PCT;
      fault_pct_reg <= RST_FAULT_PCT;
    end else if (wr_fire) begin
      unique case (avs_address)
        OFS_CTRL: short_en_reg <= avs_writedata[CTRL_SHORT_EN];
        OFS_I_THR: i_thr_reg <= avs_writedata;
        OFS_V_THR: v_thr_reg <= avs_writedata;
        OFS_I_TC: i_tc_reg <= avs_writedata;
        OFS_V_TC: v_tc_reg <= avs_writedata;
        OFS_ACT_TIME: act_time_reg <= avs_writedata;
        OFS_RAMP_TIME: ramp_time_reg <= avs_writedata;
        OFS_SAMPLE_CNT: sample_cnt_reg <= avs_writedata;
        OFS_SHORT_PCT: short_pct_reg <= avs_writedata[7:0];
        OFS_TEMP_LIMIT: temp_limit_reg <= avs_writedata[15:0];
        OFS_WARN_PCT: warn_pct_reg <= avs_writedata[7:0];
        OFS_FAULT_PCT: fault_pct_reg <= avs_writedata[7:0];
        default: begin
        end
      endcase
    end
  end

  // Per-contactor settings
  for (genvar g = 0; g < N_CONT; g++) begin : g_cfg
    logic sel;
    assign sel = wr_fire && avs_address[7:CONT_STRIDE_LOG2] == 3'(2 + g);
    assign cnt_load[g] = sel && avs_address[4:2] == CW_WEAR_CNT;
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        mon_en_reg[g] <= 1'b0;
        life_en_reg[g] <= 1'b0;
        soft_start_reg[g] <= 1'b0;
        window_reg[g] <= RST_WINDOW_US;
        min_i_reg[g] <= '0;
        max_i_reg[g] <= 32'hFFFF_FFFF;
        rated_i_reg[g] <= '0;
        max_life_reg[g] <= 32'hFFFF_FFFF;
      end else if (sel) begin
        unique case (avs_address[4:2])
          CW_CFG: begin
            mon_en_reg[g] <= avs_writedata[CC_MON_EN];
            life_en_reg[g] <= avs_writedata[CC_LIFE_EN];
            soft_start_reg[g] <= avs_writedata[CC_SOFT_START];
          end
          CW_WINDOW: window_reg[g] <= avs_writedata;
          CW_MIN_I: min_i_reg[g] <= avs_writedata;
          CW_MAX_I: max_i_reg[g] <= avs_writedata;
          CW_RATED_I: rated_i_reg[g] <= avs_writedata;
          CW_MAX_LIFE: max_life_reg[g] <= avs_writedata;
          default: begin
          end
        endcase
      end
    end
  end

  // Filter chain
  logic signed [31:0] i_abs, i_filt, v_filt, v_slow, v_fast;
  logic [31:0] i_act, v_dev_slow, v_dev_fast, v_act;
  assign i_abs = stack_current_ma[31] ? -stack_current_ma : stack_current_ma;

  scd_lpf #(.W(32)) u_i_lpf (
    .core_clk(core_clk), .arst_n(arst_n), .stb(sample_valid),
    .shift(tc_shift(i_tc_reg)), .x(i_abs), .y(i_filt)
  );
  scd_lpf #(.W(32)) u_v_lpf (
    .core_clk(core_clk), .arst_n(arst_n), .stb(sample_valid),
    .shift(tc_shift(v_tc_reg)), .x(stack_voltage_mv), .y(v_filt)
  );
  scd_lpf #(.W(32)) u_slow_lpf (
    .core_clk(core_clk), .arst_n(arst_n), .stb(sample_valid),
    .shift(tc_shift(act_time_reg)), .x(v_filt), .y(v_slow)
  );
  scd_lpf #(.W(32)) u_fast_lpf (
    .core_clk(core_clk), .arst_n(arst_n), .stb(sample_valid),
    .shift(tc_shift(ramp_time_reg)), .x(v_filt), .y(v_fast)
  );

  // Voltage activity is the larger deviation from the slow and fast trends
  assign i_act = i_filt[31] ? 32'h0 : i_filt;
  assign v_dev_slow = (v_filt > v_slow) ? 32'(v_filt - v_slow) : 32'(v_slow - v_filt);
  assign v_dev_fast = (v_filt > v_fast) ? 32'(v_filt - v_fast) : 32'(v_fast - v_filt);
  assign v_act = (v_dev_slow > v_dev_fast) ? v_dev_slow : v_dev_fast;

  // Shorted-sense decision over a block of active samples
  logic [31:0] eval_cnt_reg, bad_cnt_reg;
  logic short_reg, v_active, i_quiet, blk_done;
  logic [39:0] bad_pct, need_pct;
  assign v_active = v_act > v_thr_reg;
  assign i_quiet = i_act < i_thr_reg;
  assign blk_done = sample_valid && short_en_reg && v_active && eval_cnt_reg + 32'h1 >= sample_cnt_reg;
  assign bad_pct = (bad_cnt_reg + {31'h0, i_quiet}) * PCT_FULL;
  assign need_pct = sample_cnt_reg * short_pct_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      eval_cnt_reg <= '0;
      bad_cnt_reg <= '0;
    end else if (!short_en_reg || blk_done) begin
      eval_cnt_reg <= '0;
      bad_cnt_reg <= '0;
    end else if (sample_valid && v_active) begin
      eval_cnt_reg <= eval_cnt_reg + 32'h1;
      bad_cnt_reg <= bad_cnt_reg + {31'h0, i_quiet};
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      short_reg <= 1'b0;
    end else if (blk_done && bad_pct >= need_pct) begin
      short_reg <= 1'b1;
    end else if (clear_req && !v_active) begin
      short_reg <= 1'b0;
    end
  end

  // Temperature spread per module
  logic temp_over;
  always_comb begin
    logic signed [15:0] t, t_max, t_min;
    t = 16'sh0000;
    t_max = 16'sh8000;
    t_min = 16'sh7FFF;
    temp_over = 1'b0;
    for (int m = 0; m < N_MOD; m++) begin
      t_max = 16'sh8000;
      t_min = 16'sh7FFF;
      for (int k = 0; k < N_TH; k++) begin
        t = module_temps_c[(m*N_TH+k)*16 +: 16];
        if (t > t_max) begin
          t_max = t;
        end
        if (t < t_min) begin
          t_min = t;
        end
      end
      if (17'(t_max) - 17'(t_min) > 17'({1'b0, temp_limit_reg})) begin
        temp_over = 1'b1;
      end
    end
  end

  logic temp_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      temp_reg <= 1'b0;
    end else if (temp_over) begin
      temp_reg <= 1'b1;
    end else if (clear_req) begin
      temp_reg <= 1'b0;
    end
  end

  // Contactor wear trackers
  scd_wear_if wif[N_CONT]();
  logic [N_CONT-1:0] warn_v, trip_v, eol_v;
  logic [31:0] wear_cnt_v [N_CONT];
  for (genvar g = 0; g < N_CONT; g++) begin : g_wear
    assign wif[g].mon_en = mon_en_reg[g];
    assign wif[g].life_en = life_en_reg[g];
    assign wif[g].soft_start_flag = soft_start_reg[g];
    assign wif[g].half_win = window_reg[g] >> (LOG2_SAMPLE_US + 1);
    assign wif[g].min_i = min_i_reg[g];
    assign wif[g].max_i = max_i_reg[g];
    assign wif[g].rated_i = rated_i_reg[g];
    assign wif[g].max_life = max_life_reg[g];
    assign wif[g].warn_pct = warn_pct_reg;
    assign wif[g].trip_pct = fault_pct_reg;
    assign wif[g].cnt_load = cnt_load[g];
    assign wif[g].cnt_val = avs_writedata;
    assign warn_v[g] = wif[g].warn;
    assign trip_v[g] = wif[g].trip;
    assign eol_v[g] = wif[g].eol;
    assign wear_cnt_v[g] = wif[g].wear_cnt;
    scd_wear u_wear (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .stb(sample_valid),
      .cur_abs(i_abs),
      .open_evt(contactor_open[g]),
      .open_lost(contactor_open_lost[g]),
      .clear(clear_req),
      .w(wif[g])
    );
  end

  // Read mux; unmapped words read as zero
  always_comb begin
    int c;
    c = 0;
    rdata_next = 32'h0;
    unique case (avs_address)
      OFS_CTRL: rdata_next = {31'h0, short_en_reg};
      OFS_STATUS: rdata_next = {28'h0, |trip_v, |warn_v, temp_reg, short_reg};
      OFS_I_THR: rdata_next = i_thr_reg;
      OFS_V_THR: rdata_next = v_thr_reg;
      OFS_I_TC: rdata_next = i_tc_reg;
      OFS_V_TC: rdata_next = v_tc_reg;
      OFS_ACT_TIME: rdata_next = act_time_reg;
      OFS_RAMP_TIME: rdata_next = ramp_time_reg;
      OFS_SAMPLE_CNT: rdata_next = sample_cnt_reg;
      OFS_SHORT_PCT: rdata_next = {24'h0, short_pct_reg};
      OFS_TEMP_LIMIT: rdata_next = {16'h0, temp_limit_reg};
      OFS_WARN_PCT: rdata_next = {24'h0, warn_pct_reg};
      OFS_FAULT_PCT: rdata_next = {24'h0, fault_pct_reg};
      OFS_V_ACT: rdata_next = v_act;
      OFS_I_FILT: rdata_next = i_act;
      default: begin
        c = int'(avs_address[7:CONT_STRIDE_LOG2]) - 2;
        for (int g = 0; g < N_CONT; g++) begin
          if (g == c) begin
            unique case (avs_address[4:2])
              CW_CFG: rdata_next = {29'h0, soft_start_reg[g], life_en_reg[g], mon_en_reg[g]};
              CW_WINDOW: rdata_next = window_reg[g];
              CW_MIN_I: rdata_next = min_i_reg[g];
              CW_MAX_I: rdata_next = max_i_reg[g];
              CW_RATED_I: rdata_next = rated_i_reg[g];
              CW_MAX_LIFE: rdata_next = max_life_reg[g];
              CW_WEAR_CNT: rdata_next = wear_cnt_v[g];
              CW_STATUS: rdata_next = {29'h0, trip_v[g], warn_v[g], eol_v[g]};
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= '0;
    end else if (rd_fire) begin
      avs_readdata <= rdata_next;
    end
  end

  // Flag outputs
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      short_sense_trip <= 1'b0;
      module_temp_spread_trip <= 1'b0;
      wearout_warning_level <= 1'b0;
      wearout_trip_level <= 1'b0;
      contactor_eol <= '0;
    end else begin
      short_sense_trip <= short_reg;
      module_temp_spread_trip <= temp_reg;
      wearout_warning_level <= |warn_v;
      wearout_trip_level <= |trip_v;
      contactor_eol <= eol_v;
    end
  end
endmodule

// ===== logic/scd_lpf.sv
// First-order low-pass filter stepped once per sample strobe
`timescale 1ns/1ps
module scd_lpf import scd_pkg::*; #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Sample
  input wire logic stb,
  input wire logic [4:0] shift,
  input wire logic signed [W-1:0] x,
  // Filtered value
  output logic signed [W-1:0] y
);
  logic signed [W+LPF_FRAC-1:0] acc_reg;
  logic signed [W+LPF_FRAC:0] diff;
  logic signed [W+LPF_FRAC:0] step;

  // Extra fraction bits keep long time constants from stalling on rounding
  assign diff = {x[W-1], x, {LPF_FRAC{1'b0}}} - {acc_reg[W+LPF_FRAC-1], acc_reg};
  assign step = diff >>> shift;
  assign y = acc_reg[W+LPF_FRAC-1:LPF_FRAC];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg <= '0;
    end else if (stb) begin
      acc_reg <= acc_reg + step[W+LPF_FRAC-1:0];
    end
  end
endmodule

// ===== logic/scd_pkg.sv
// Shared constants for the stack sense and contactor diagnostic block
package scd_pkg;
  // Global register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_I_THR = 8'h08;
  localparam logic [7:0] OFS_V_THR = 8'h0C;
  localparam logic [7:0] OFS_I_TC = 8'h10;
  localparam logic [7:0] OFS_V_TC = 8'h14;
  localparam logic [7:0] OFS_ACT_TIME = 8'h18;
  localparam logic [7:0] OFS_RAMP_TIME = 8'h1C;
  localparam logic [7:0] OFS_SAMPLE_CNT = 8'h20;
  localparam logic [7:0] OFS_SHORT_PCT = 8'h24;
  localparam logic [7:0] OFS_TEMP_LIMIT = 8'h28;
  localparam logic [7:0] OFS_WARN_PCT = 8'h2C;
  localparam logic [7:0] OFS_FAULT_PCT = 8'h30;
  localparam logic [7:0] OFS_V_ACT = 8'h34;
  localparam logic [7:0] OFS_I_FILT = 8'h38;
  // Per-contactor block: base + index * stride, word offsets inside
  localparam logic [7:0] OFS_CONT_BASE = 8'h40;
  localparam int CONT_STRIDE_LOG2 = 5;
  localparam logic [2:0] CW_CFG = 3'h0;
  localparam logic [2:0] CW_WINDOW = 3'h1;
  localparam logic [2:0] CW_MIN_I = 3'h2;
  localparam logic [2:0] CW_MAX_I = 3'h3;
  localparam logic [2:0] CW_RATED_I = 3'h4;
  localparam logic [2:0] CW_MAX_LIFE = 3'h5;
  localparam logic [2:0] CW_WEAR_CNT = 3'h6;
  localparam logic [2:0] CW_STATUS = 3'h7;
  // Field positions
  localparam int CTRL_SHORT_EN = 0;
  localparam int CTRL_CLEAR = 1;
  localparam int ST_SHORT = 0;
  localparam int ST_TEMP = 1;
  localparam int ST_WARN = 2;
  localparam int ST_TRIP = 3;
  localparam int CC_MON_EN = 0;
  localparam int CC_LIFE_EN = 1;
  localparam int CC_SOFT_START = 2;
  // Reset values and the percent scale
  localparam logic RST_SHORT_EN = 1'b1;
  localparam logic [31:0] RST_I_THR = 32'h0000_0000;
  localparam logic [31:0] RST_V_THR = 32'h0000_0000;
  localparam logic [31:0] RST_TC_US = 32'd1000000;
  localparam logic [31:0] RST_ACT_US = 32'd180000000;
  localparam logic [31:0] RST_RAMP_US = 32'd10000000;
  localparam logic [31:0] RST_SAMPLE_CNT = 32'd100;
  localparam logic [7:0] RST_SHORT_PCT = 8'd50;
  localparam logic [15:0] RST_TEMP_LIMIT = 16'd15;
  localparam logic [7:0] RST_WARN_PCT = 8'd20;
  localparam logic [7:0] RST_FAULT_PCT = 8'd0;
  localparam logic [31:0] RST_WINDOW_US = 32'd2000000;
  localparam logic [7:0] PCT_FULL = 8'd100;
  // Filter fraction bits and largest shift
  localparam int LPF_FRAC = 16;
  localparam logic [4:0] LPF_MAX_SHIFT = 5'd24;
endpackage

// ===== logic/scd_wear.sv
// Wear tracker for one contactor: opening current capture and life count
`timescale 1ns/1ps
module scd_wear import scd_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Measurements and events
  input wire logic stb,
  input wire logic [31:0] cur_abs,
  input wire logic open_evt,
  input wire logic open_lost,
  input wire logic clear,
  // Settings and status
  scd_wear_if.trk w
);
  typedef enum logic [0:0] {SCD_IDLE, SCD_POST} scd_wear_state_e;
  scd_wear_state_e state_reg;
  logic [31:0] blk_cnt_reg, blk_max_reg, prev_max_reg, post_cnt_reg, peak_reg, cnt_reg;
  logic eol_reg, warn_reg, trip_reg;
  logic eval, mon_open;
  logic [31:0] eval_i, remain;
  logic [39:0] rem_pct, warn_lim, trip_lim;

  assign mon_open = open_evt && w.mon_en && w.life_en;
  assign eval = (state_reg == SCD_POST && stb && post_cnt_reg == 32'h0)
             || (w.life_en && ((open_evt && !w.mon_en) || open_lost));
  assign eval_i = (state_reg == SCD_POST) ? peak_reg : w.rated_i;
  assign remain = (cnt_reg >= w.max_life) ? 32'h0 : w.max_life - cnt_reg;
  assign rem_pct = remain * PCT_FULL;
  assign warn_lim = w.max_life * w.warn_pct;
  assign trip_lim = w.max_life * w.trip_pct;

  // Two half-window blocks of maxima cover the samples before an opening
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      blk_cnt_reg <= '0;
      blk_max_reg <= '0;
      prev_max_reg <= '0;
    end else if (stb) begin
      if (blk_cnt_reg >= w.half_win) begin
        blk_cnt_reg <= '0;
        prev_max_reg <= (cur_abs > blk_max_reg) ? cur_abs : blk_max_reg;
        blk_max_reg <= '0;
      end else begin
        blk_cnt_reg <= blk_cnt_reg + 32'h1;
        blk_max_reg <= (cur_abs > blk_max_reg) ? cur_abs : blk_max_reg;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= SCD_IDLE;
      post_cnt_reg <= '0;
      peak_reg <= '0;
    end else begin
      unique case (state_reg)
        SCD_IDLE: begin
          if (mon_open) begin
            state_reg <= SCD_POST;
            post_cnt_reg <= w.half_win;
            peak_reg <= (prev_max_reg > blk_max_reg) ? prev_max_reg : blk_max_reg;
          end
        end
        SCD_POST: begin
          if (stb) begin
            peak_reg <= (cur_abs > peak_reg) ? cur_abs : peak_reg;
            if (post_cnt_reg == 32'h0) begin
              state_reg <= SCD_IDLE;
            end else begin
              post_cnt_reg <= post_cnt_reg - 32'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else if (w.cnt_load) begin
      cnt_reg <= w.cnt_val;
    end else if (eval && w.life_en && eval_i > w.min_i && cnt_reg != 32'hFFFF_FFFF) begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end

  // Flags stick; a clear only drops a flag whose cause has gone
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      eol_reg <= 1'b0;
      warn_reg <= 1'b0;
      trip_reg <= 1'b0;
    end else begin
      if ((eval && eval_i > w.max_i) || cnt_reg > w.max_life) begin
        eol_reg <= 1'b1;
      end else if (clear) begin
        eol_reg <= 1'b0;
      end
      if (w.life_en && rem_pct < warn_lim) begin
        warn_reg <= 1'b1;
      end else if (clear) begin
        warn_reg <= 1'b0;
      end
      if (eol_reg || (w.life_en && rem_pct < trip_lim)) begin
        trip_reg <= 1'b1;
      end else if (clear) begin
        trip_reg <= 1'b0;
      end
    end
  end

  assign w.wear_cnt = cnt_reg;
  assign w.eol = eol_reg;
  assign w.warn = warn_reg;
  assign w.trip = trip_reg;
endmodule

// ===== logic/scd_wear_if.sv
// Settings and status carried between the core and one contactor wear tracker
`timescale 1ns/1ps
interface scd_wear_if;
  logic mon_en;
  logic life_en;
  logic soft_start_flag;
  logic [31:0] half_win;
  logic [31:0] min_i;
  logic [31:0] max_i;
  logic [31:0] rated_i;
  logic [31:0] max_life;
  logic [7:0] warn_pct;
  logic [7:0] trip_pct;
  logic cnt_load;
  logic [31:0] cnt_val;
  logic [31:0] wear_cnt;
  logic eol;
  logic warn;
  logic trip;
  modport ctl (output mon_en, life_en, soft_start_flag, half_win, min_i, max_i, rated_i, max_life,
               warn_pct, trip_pct, cnt_load, cnt_val, input wear_cnt, eol, warn, trip);
  modport trk (input mon_en, life_en, soft_start_flag, half_win, min_i, max_i, rated_i, max_life,
               warn_pct, trip_pct, cnt_load, cnt_val, output wear_cnt, eol, warn, trip);
endinterface

// ===== tb/scd_core_tb_top.sv
// Self-checking bench for the diagnostic core
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module scd_core_tb_top import scd_pkg::*;;
  logic core_clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, sample_valid;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, e_now;
  logic signed [31:0] cur_set = 0, volt_set = 0, stack_current_ma, stack_voltage_mv;
  logic [63:0] temps = 64'h0;
  logic [15:0] t;
  logic [1:0] c_lost = 2'h0, c_open = 2'h0;
  logic [5:0] flags;
  logic [31:0] exp_q[$];
  int fails = 0, n_compared = 0, cyc = 0;
  always #2.5 core_clk = ~core_clk;
  scd_core #(.N_MOD(2), .N_TH(2), .N_CONT(2)) dut (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sample_valid(sample_valid), .stack_current_ma(stack_current_ma),
    .stack_voltage_mv(stack_voltage_mv), .module_temps_c(temps), .contactor_open(c_open),
    .contactor_open_lost(c_lost), .short_sense_trip(flags[5]), .module_temp_spread_trip(flags[4]),
    .wearout_warning_level(flags[3]), .wearout_trip_level(flags[2]), .contactor_eol(flags[1:0]));
  scd_front_model u_front (.core_clk(core_clk), .arst_n(arst_n), .cur_set(cur_set), .volt_set(volt_set),
    .sample_valid(sample_valid), .stack_current_ma(stack_current_ma), .stack_voltage_mv(stack_voltage_mv));
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic rd);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    if (rd) exp_q.push_back(d);
    if (rd) avs_read <= 1'b1;
    else avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  always @(posedge core_clk) begin
    if (avs_read && !avs_waitrequest) begin
      e_now = exp_q.pop_front();
      `CHK("readdata", e_now, avs_readdata)
    end
  end
  task automatic give_verdict;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Whole run needs well under two thousand clocks
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(56515));
    t = 16'(20 + $urandom_range(10));
    temps = {4{t}};
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    cur_set <= 11 + $urandom_range(5000);
    bus(OFS_CTRL, 32'h1, 1'b1);
    bus(OFS_SAMPLE_CNT, RST_SAMPLE_CNT, 1'b1);
    bus(OFS_SHORT_PCT, 32'(RST_SHORT_PCT), 1'b1);
    bus(OFS_TEMP_LIMIT, 32'(RST_TEMP_LIMIT), 1'b1);
    bus(OFS_FAULT_PCT, 32'(RST_FAULT_PCT), 1'b1);
    bus(OFS_CONT_BASE + 8'h04, RST_WINDOW_US, 1'b1);
    bus(8'h3C, 32'h0, 1'b1);
    temps[63:48] <= t + 16'd15;
    repeat (20) @(posedge core_clk);
    bus(OFS_STATUS, 32'h0, 1'b1);
    temps[63:48] <= t + 16'd16;
    repeat (20) @(posedge core_clk);
    bus(OFS_STATUS, 32'h2, 1'b1);
    @(negedge core_clk);
    `CHK("temp_pin", 1'b1, flags[4])
    bus(OFS_CTRL, 32'h3, 1'b0);
    bus(OFS_STATUS, 32'h2, 1'b1);
    temps <= {4{t}};
    repeat (20) @(posedge core_clk);
    bus(OFS_STATUS, 32'h2, 1'b1);
    bus(OFS_CTRL, 32'h3, 1'b0);
    bus(OFS_STATUS, 32'h0, 1'b1);
    bus(8'h4C, 32'd10, 1'b0);
    bus(8'h50, 32'(11 + $urandom_range(1000)), 1'b0);
    bus(8'h40, 32'h6, 1'b0);
    c_lost <= 2'h3;
    @(posedge core_clk);
    c_lost <= 2'h0;
    repeat (8) @(posedge core_clk);
    bus(8'h58, 32'h1, 1'b1);
    bus(8'h5C, 32'h5, 1'b1);
    bus(8'h40, 32'h6, 1'b1);
    bus(8'h78, 32'h0, 1'b1);
    bus(8'h7C, 32'h0, 1'b1);
    bus(8'h60, 32'h2, 1'b0);
    bus(8'h74, 32'h3, 1'b0);
    bus(8'h78, 32'h4, 1'b0);
    repeat (8) @(posedge core_clk);
    bus(8'h7C, 32'h7, 1'b1);
    bus(OFS_STATUS, 32'hC, 1'b1);
    bus(OFS_I_THR, 32'h7FFF_FFFF, 1'b0);
    bus(OFS_SAMPLE_CNT, 32'h4, 1'b0);
    volt_set <= 32'sh0010_0000;
    repeat (40) @(posedge core_clk);
    bus(OFS_STATUS, 32'hD, 1'b1);
    bus(OFS_CTRL, 32'h3, 1'b0);
    bus(OFS_STATUS, 32'hD, 1'b1);
    bus(8'h44, 32'h1000, 1'b0);
    bus(8'h40, 32'h7, 1'b0);
    c_open <= 2'h1;
    @(posedge core_clk);
    c_open <= 2'h0;
    repeat (30) @(posedge core_clk);
    bus(8'h58, 32'h2, 1'b1);
    @(negedge core_clk);
    `CHK("flag_pins", 6'h2F, flags)
    give_verdict();
  end
endmodule

// ===== tb/scd_front_model.sv
// Front end model: bench values with a strobe every fourth clock
`timescale 1ns/1ps
module scd_front_model (
  input logic core_clk, input logic arst_n, input logic signed [31:0] cur_set, input logic signed [31:0] volt_set,
  output logic sample_valid, output logic signed [31:0] stack_current_ma, output logic signed [31:0] stack_voltage_mv
);
  logic [1:0] div_reg;
  // Values move only with the strobe, as a converter hands over results
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 2'h0;
      sample_valid <= 1'b0;
    end else begin
      div_reg <= div_reg + 2'h1;
      sample_valid <= div_reg == 2'h3;
      if (div_reg == 2'h3) stack_current_ma <= cur_set;
      if (div_reg == 2'h3) stack_voltage_mv <= volt_set;
    end
  end
endmodule

// ===== tb/scd_properties.sv
// Port checker for the diagnostic core
`timescale 1ns/1ps
module scd_properties #(
  parameter int N_CONT = 2
) (
  // Clock, reset, bus
  input logic core_clk, input logic arst_n,
  input logic avs_read, input logic avs_write, input logic avs_waitrequest, input logic sample_valid,
  // Flags
  input logic short_sense_trip, input logic module_temp_spread_trip,
  input logic wearout_warning_level, input logic wearout_trip_level, input logic [N_CONT-1:0] contactor_eol
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // A clear lands two edges before its flag can fall
  logic [2:0] wr_hist;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) wr_hist <= 3'h0;
    else wr_hist <= {wr_hist[1:0], avs_write};
  end
  property p_wait; ($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("no wait state");
  property p_ack; avs_waitrequest && (avs_read || avs_write) |=> !avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("access not acknowledged");
  property p_short_src; $rose(short_sense_trip) |-> $past(sample_valid, 2); endproperty
  a_short_src: assert property (p_short_src) else $error("short trip without sample");
  property p_short_hold; $fell(short_sense_trip) |-> |wr_hist; endproperty
  a_short_hold: assert property (p_short_hold) else $error("short trip fell without clear");
  property p_temp_hold; $fell(module_temp_spread_trip) |-> |wr_hist; endproperty
  a_temp_hold: assert property (p_temp_hold) else $error("spread trip fell without clear");
  property p_warn_hold; $fell(wearout_warning_level) |-> |wr_hist; endproperty
  a_warn_hold: assert property (p_warn_hold) else $error("warning fell without clear");
  property p_trip_hold; $fell(wearout_trip_level) |-> |wr_hist; endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("wear trip fell without clear");
  property p_trip_eol; |contactor_eol |-> ##[0:2] wearout_trip_level; endproperty
  a_trip_eol: assert property (p_trip_eol) else $error("end of life without wear trip");
  cover property ($rose(module_temp_spread_trip));
  cover property ($fell(module_temp_spread_trip));
  cover property ($rose(contactor_eol[1]));
  cover property ($rose(short_sense_trip));
endmodule
bind scd_core scd_properties #(.N_CONT(N_CONT)) u_props (.core_clk(core_clk), .arst_n(arst_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .sample_valid(sample_valid),
  .short_sense_trip(short_sense_trip), .module_temp_spread_trip(module_temp_spread_trip),
  .wearout_warning_level(wearout_warning_level), .wearout_trip_level(wearout_trip_level),
  .contactor_eol(contactor_eol));
